// *** logic/pin_mux_cfg.svh ***
// Constants for the mode pin function multiplexer
`ifndef PIN_MUX_CFG_SVH
`define PIN_MUX_CFG_SVH

// Core clock period and external clock loss timeout
`define CLK_PERIOD_NS   20
`define CLK_LOSS_NS     1000
`define CLK_LOSS_CYCLES (`CLK_LOSS_NS / `CLK_PERIOD_NS)

// Strap positions in the standalone configuration word
`define STRAP_SOUT   0
`define STRAP_SIN    1
`define STRAP_SCLK   2
`define STRAP_CHIPSEL 3
`define STRAP_ENC_B  4
`define STRAP_ENC_A  5
`define STRAP_ENC_N  6
`define STRAP_W      7

// Reset value of every register group
`define RST_ZERO '0
// Constant drive levels
`define LVL_LO 1'b0
`define LVL_HI 1'b1

`endif

// *** logic/pin_mux_pkg.sv ***
// Types for the mode pin function multiplexer
package pin_mux_pkg;

  // Operating mode, coded as {step_dir_select, serial_port_select}
  typedef enum logic [1:0] {
    MODE_WIRE_RAMP   = 2'b00,
    MODE_SPI_RAMP    = 2'b01,
    MODE_STANDALONE  = 2'b10,
    MODE_SPI_STEPDIR = 2'b11
  } mode_t;

  // Raw levels arriving on the pins
  typedef struct packed {
    logic step_dir_select;
    logic serial_port_select;
    logic chipsel_or_strap3;
    logic sclk_or_strap2;
    logic sin_or_strap1;
    logic sout_or_strap0;
    logic left_ref_or_step_in;
    logic right_ref_or_dir_in;
    logic enc_b_or_speedctl_enable;
    logic enc_a_or_speedctl_gate;
    logic enc_index_or_speedctl_ready;
    logic diag_first_or_wire_neg;
    logic diag_second_or_wire_pos;
    logic bridge_disable_n;
    logic ext_clock;
  } pin_in_t;

  // Drive of the two-way pins
  typedef struct packed {
    logic sout_o;
    logic sout_oe;
    logic enc_n_o;
    logic enc_n_oe;
    logic diag_first_o;
    logic diag_first_oe;
    logic diag_second_o;
    logic diag_second_oe;
  } pin_out_t;

  // Signals produced by the internal core
  typedef struct packed {
    logic spi_sout;
    logic spi_sout_en;
    logic diag_first;
    logic diag_second;
    logic diag_open_drain;
    logic ramp_step;
    logic ramp_dir;
    logic speedctl_ready;
    logic wire_tx;
    logic wire_tx_en;
    logic next_addr_out;
  } core_out_t;

  // Decoded pin functions handed to the internal core
  typedef struct packed {
    mode_t      mode;
    logic       spi_enable;
    logic       wire_enable;
    logic       standalone;
    logic       step_dir_active;
    logic       spi_chipsel_n;
    logic       spi_sclk;
    logic       spi_sin;
    logic [6:0] straps;
    logic       left_ref;
    logic       right_ref;
    logic       enc_a;
    logic       enc_b;
    logic       enc_index;
    logic       speedctl_enable;
    logic       speedctl_gate;
    logic       wire_rx;
    logic       next_addr_in;
  } core_in_t;

  // Motor step source and power stage control
  typedef struct packed {
    logic step;
    logic dir;
    logic power_enable;
    logic outputs_float;
  } motor_t;

endpackage : pin_mux_pkg

// *** logic/mode_pin_function_mux.sv ***
// Pin function multiplexer steered by the two mode select straps
//
// Function
// R1: Low select: ramp generator makes step pulses
// R2: High select: external step/dir drive motor
// R3: Wire UART only when both selects low
// R4: Serial low, step/dir high: standalone straps
// R5: Serial select high enables SPI; pulled low
// R6: Four serial pins: SPI or config inputs
// R7: Wire mode: serial pins carry next-address
// R8: Reference switches become step/dir when selected
// R9: Encoder B: input, speed enable, or strap
// R10: Encoder A: input or speed gating input
// R11: Encoder index input, or speed ready output
// R12: First diag pin: diagnostics, interrupt, step
// R13: Second diag pin: diagnostics, compare, direction
// R14: Both selects low: diag pins form wire
// R15: Bridge disable high floats all motor outputs
// R16: Tied-low clock uses internal; fail over
// R17: Host may drive wire differential or single
// R18: Board holds mode selects static while running
`include "pin_mux_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module mode_pin_function_mux
  import pin_mux_pkg::*;
#(
  parameter int CLK_LOSS_CYCLES = `CLK_LOSS_CYCLES, // Cycles without edge before fail over
  parameter int LOSS_CNT_W      = 8                 // Width of the loss counter
) (
  input  wire logic      clock,            // Core clock, 50 MHz
  input  wire logic      arst_n,           // Asynchronous reset, active low
  input  wire pin_in_t   pins_in,          // Raw pin levels, asynchronous
  output var  pin_out_t  pins_out,         // Two-way pin drive and enables
  input  wire core_out_t core_out,         // Signals from the internal core
  output var  core_in_t  core_in,          // Decoded pin functions to the core
  output var  motor_t    motor,            // Step source and power stage control
  output var  logic      clk_use_external, // High while the external clock is running
  output var  logic      clk_lost          // One-cycle pulse when external clock stops
);

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  pin_in_t sync1_r;   // First stage, read only by the second stage
  pin_in_t sync2_r;   // Second stage, safe to decode
  pin_in_t sync1_nxt; // Next value of first stage
  pin_in_t sync2_nxt; // Next value of second stage

  // Next values of the two synchroniser stages
  always_comb begin
    sync1_nxt = pins_in;
    sync2_nxt = sync1_r;
  end

  // Two flip-flops before any logic looks at a pin
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= `RST_ZERO;
      sync2_r <= `RST_ZERO;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Clock source monitor
  // ------------------------------------------------------------------
  logic                  clk_prev_r;   // Last synchronised external clock level
  logic                  clk_prev_nxt; // Next value of the above
  logic [LOSS_CNT_W-1:0] loss_cnt_r;   // Cycles since the last external edge
  logic [LOSS_CNT_W-1:0] loss_cnt_nxt; // Next value of the loss counter
  logic                  ext_run_r;    // External clock seen running
  logic                  ext_run_nxt;  // Next value of the above
  logic                  lost_r;       // Loss pulse register
  logic                  lost_nxt;     // Next value of the loss pulse
  logic                  clk_edge;     // Any edge seen on the external clock

  // Edge detect and timeout; the pin is sampled, so only clocks well
  // below half the core rate are tracked faithfully
  always_comb begin
    clk_prev_nxt = sync2_r.ext_clock;
    clk_edge     = sync2_r.ext_clock ^ clk_prev_r;
    loss_cnt_nxt = loss_cnt_r;
    ext_run_nxt  = ext_run_r;
    lost_nxt     = `LVL_LO;
    if (clk_edge) begin
      // Activity restarts the timeout and selects the external source
      loss_cnt_nxt = `RST_ZERO;
      ext_run_nxt  = `LVL_HI;                                        // R16
    end else if (loss_cnt_r == LOSS_CNT_W'(CLK_LOSS_CYCLES)) begin
      // Timeout: fall back to the internal oscillator and stop counting
      ext_run_nxt  = `LVL_LO;                                        // R16
      lost_nxt     = ext_run_r;
    end else begin
      // Count idle cycles; a pin tied low never leaves internal mode
      loss_cnt_nxt = loss_cnt_r + LOSS_CNT_W'(1);
    end
  end

  // Clock monitor registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      clk_prev_r <= `LVL_LO;
      loss_cnt_r <= `RST_ZERO;
      ext_run_r  <= `LVL_LO;
      lost_r     <= `LVL_LO;
    end else begin
      clk_prev_r <= clk_prev_nxt;
      loss_cnt_r <= loss_cnt_nxt;
      ext_run_r  <= ext_run_nxt;
      lost_r     <= lost_nxt;
    end
  end

  assign clk_use_external = ext_run_r;
  assign clk_lost         = lost_r;

  // ------------------------------------------------------------------
  // Mode decode and pin routing
  // ------------------------------------------------------------------
  core_in_t core_in_r;   // Registered decoded functions
  core_in_t core_in_nxt; // Next decoded functions
  pin_out_t pins_out_r;  // Registered pin drive
  pin_out_t pins_out_nxt;// Next pin drive
  motor_t   motor_r;     // Registered motor control
  motor_t   motor_nxt;   // Next motor control
  mode_t    mode;        // Current mode from the synchronised selects

  // Mode straps are expected static during operation, so no glitch
  // filter is spent on them beyond the synchroniser
  assign mode = mode_t'({sync2_r.step_dir_select, sync2_r.serial_port_select}); // R18

  // Route every shared pin according to the mode
  always_comb begin
    core_in_nxt = `RST_ZERO;
    pins_out_nxt = `RST_ZERO;
    motor_nxt   = `RST_ZERO;
    core_in_nxt.mode = mode;

    // Straps mirror the pins in every mode; the core uses them standalone
    core_in_nxt.straps[`STRAP_SOUT]    = sync2_r.sout_or_strap0;
    core_in_nxt.straps[`STRAP_SIN]     = sync2_r.sin_or_strap1;
    core_in_nxt.straps[`STRAP_SCLK]    = sync2_r.sclk_or_strap2;
    core_in_nxt.straps[`STRAP_CHIPSEL] = sync2_r.chipsel_or_strap3;
    core_in_nxt.straps[`STRAP_ENC_B]   = sync2_r.enc_b_or_speedctl_enable;
    core_in_nxt.straps[`STRAP_ENC_A]   = sync2_r.enc_a_or_speedctl_gate;
    core_in_nxt.straps[`STRAP_ENC_N]   = sync2_r.enc_index_or_speedctl_ready;

    // Idle SPI select reads inactive outside SPI modes
    core_in_nxt.spi_chipsel_n = `LVL_HI;

    case (mode)
      MODE_WIRE_RAMP: begin
        // Single-wire interface with ramp generator
        core_in_nxt.wire_enable   = `LVL_HI;                          // R3
        core_in_nxt.next_addr_in  = sync2_r.sin_or_strap1;            // R7
        pins_out_nxt.sout_o       = core_out.next_addr_out;           // R7
        pins_out_nxt.sout_oe      = `LVL_HI;                          // R7
        // Receive on the positive line so an open negative line works
        core_in_nxt.wire_rx       = sync2_r.diag_second_or_wire_pos;  // R17
        pins_out_nxt.diag_second_o  = core_out.wire_tx;               // R14
        pins_out_nxt.diag_second_oe = core_out.wire_tx_en;            // R14
        pins_out_nxt.diag_first_o   = ~core_out.wire_tx;              // R14
        pins_out_nxt.diag_first_oe  = core_out.wire_tx_en;            // R14
        core_in_nxt.left_ref      = sync2_r.left_ref_or_step_in;      // R8
        core_in_nxt.right_ref     = sync2_r.right_ref_or_dir_in;      // R8
        core_in_nxt.enc_a         = sync2_r.enc_a_or_speedctl_gate;   // R10
        core_in_nxt.enc_b         = sync2_r.enc_b_or_speedctl_enable; // R9
        core_in_nxt.enc_index     = sync2_r.enc_index_or_speedctl_ready; // R11
        motor_nxt.step            = core_out.ramp_step;               // R1
        motor_nxt.dir             = core_out.ramp_dir;                // R1
      end
      MODE_SPI_RAMP: begin
        // SPI with ramp generator; diag pins carry diagnostics
        core_in_nxt.spi_enable    = `LVL_HI;                          // R5
        core_in_nxt.spi_chipsel_n = sync2_r.chipsel_or_strap3;        // R6
        core_in_nxt.spi_sclk      = sync2_r.sclk_or_strap2;           // R6
        core_in_nxt.spi_sin       = sync2_r.sin_or_strap1;            // R6
        pins_out_nxt.sout_o       = core_out.spi_sout;                // R6
        // Output floats unless selected, so several slaves may share it
        pins_out_nxt.sout_oe      = core_out.spi_sout_en & ~sync2_r.chipsel_or_strap3; // R6
        core_in_nxt.left_ref      = sync2_r.left_ref_or_step_in;      // R8
        core_in_nxt.right_ref     = sync2_r.right_ref_or_dir_in;      // R8
        core_in_nxt.enc_a         = sync2_r.enc_a_or_speedctl_gate;   // R10
        core_in_nxt.enc_b         = sync2_r.enc_b_or_speedctl_enable; // R9
        core_in_nxt.enc_index     = sync2_r.enc_index_or_speedctl_ready; // R11
        // Open drain: drive low only, external pull-up gives the high
        if (core_out.diag_open_drain) begin
          pins_out_nxt.diag_first_oe  = ~core_out.diag_first;        // R12
          pins_out_nxt.diag_second_oe = ~core_out.diag_second;       // R13
        end else begin
          pins_out_nxt.diag_first_o   = core_out.diag_first;         // R12
          pins_out_nxt.diag_first_oe  = `LVL_HI;                      // R12
          pins_out_nxt.diag_second_o  = core_out.diag_second;        // R13
          pins_out_nxt.diag_second_oe = `LVL_HI;                      // R13
        end
        motor_nxt.step            = core_out.ramp_step;               // R1
        motor_nxt.dir             = core_out.ramp_dir;                // R1
      end
      MODE_STANDALONE: begin
        // Serial pins are straps only; nothing drives them
        core_in_nxt.standalone      = `LVL_HI;                        // R4
        core_in_nxt.step_dir_active = `LVL_HI;                        // R2
        motor_nxt.step            = sync2_r.left_ref_or_step_in;      // R8
        motor_nxt.dir             = sync2_r.right_ref_or_dir_in;      // R8
        pins_out_nxt.enc_n_o      = core_out.speedctl_ready;          // R11
        pins_out_nxt.enc_n_oe     = `LVL_HI;                          // R11
      end
      MODE_SPI_STEPDIR: begin
        // SPI configuration with external step and direction
        core_in_nxt.spi_enable      = `LVL_HI;                        // R5
        core_in_nxt.step_dir_active = `LVL_HI;                        // R2
        core_in_nxt.spi_chipsel_n = sync2_r.chipsel_or_strap3;        // R6
        core_in_nxt.spi_sclk      = sync2_r.sclk_or_strap2;           // R6
        core_in_nxt.spi_sin       = sync2_r.sin_or_strap1;            // R6
        pins_out_nxt.sout_o       = core_out.spi_sout;                // R6
        pins_out_nxt.sout_oe      = core_out.spi_sout_en & ~sync2_r.chipsel_or_strap3; // R6
        motor_nxt.step            = sync2_r.left_ref_or_step_in;      // R8
        motor_nxt.dir             = sync2_r.right_ref_or_dir_in;      // R8
        // Pulled-down pin leaves speed limiting off when open
        core_in_nxt.speedctl_enable = sync2_r.enc_b_or_speedctl_enable; // R9
        core_in_nxt.speedctl_gate   = sync2_r.enc_a_or_speedctl_gate;   // R10
        pins_out_nxt.enc_n_o      = core_out.speedctl_ready;          // R11
        pins_out_nxt.enc_n_oe     = `LVL_HI;                          // R11
      end
      default: begin
        // Unreachable with two select bits; keep everything released
        motor_nxt.step = `LVL_LO;
      end
    endcase

    // Power stage follows the disable pin in every mode
    motor_nxt.power_enable  = ~sync2_r.bridge_disable_n;              // R15
    motor_nxt.outputs_float = sync2_r.bridge_disable_n;               // R15
    // No steps reach a floating bridge
    if (sync2_r.bridge_disable_n) begin
      motor_nxt.step = `LVL_LO;                                       // R15
    end
  end

  // Routing registers; every data output leaves from a flip-flop
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      core_in_r  <= `RST_ZERO;
      pins_out_r <= `RST_ZERO;
      motor_r    <= `RST_ZERO;
    end else begin
      core_in_r  <= core_in_nxt;
      pins_out_r <= pins_out_nxt;
      motor_r    <= motor_nxt;
    end
  end

  assign core_in  = core_in_r;
  assign pins_out = pins_out_r;
  assign motor    = motor_r;

endmodule : mode_pin_function_mux

`default_nettype wire

// *** tb/mode_pin_function_mux_assertions.sv ***
// Assertions for the mode pin function multiplexer
`timescale 1ns/100ps
`default_nettype none

module mode_pin_function_mux_assertions
  import pin_mux_pkg::*;
(
  input wire logic      clock,            // Core clock
  input wire logic      arst_n,           // Async reset
  input wire pin_in_t   pins_in,          // Pin levels
  input wire pin_out_t  pins_out,         // Pin drive
  input wire core_out_t core_out,         // Core signals
  input wire core_in_t  core_in,          // Decoded functions
  input wire motor_t    motor,            // Motor control
  input wire logic      clk_use_external, // External clock in use
  input wire logic      clk_lost          // Loss pulse
);
  logic [2:0] up_r;   // Edges since release
  logic [2:0] up_nxt; // Saturating next count
  logic       ok;     // History holds no pre-reset samples
  logic       sd;     // Step/dir select pin
  logic       sp;     // Serial select pin
  logic       br;     // Bridge disable pin
  assign sd = pins_in.step_dir_select;
  assign sp = pins_in.serial_port_select;
  assign br = pins_in.bridge_disable_n;
  assign ok = up_r >= 3'h3;
  // Saturate so the count never wraps into a false reset
  always_comb begin
    up_nxt = (up_r == 3'h7) ? up_r : up_r + 3'h1;
  end
  // Register the edge count
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      up_r <= 3'h0;
    end else begin
      up_r <= up_nxt;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // External clock use ends
  sequence drop_s;
    $past(clk_use_external) && !clk_use_external;
  endsequence
  // Ramp generator owns the step output
  sequence ramp_s;
    ok && !$past(sd, 3) && !$past(br, 3);
  endsequence
  wire_enable_a: assert property (
    ok |-> core_in.wire_enable == (!$past(sd, 3) && !$past(sp, 3)))
    else $error("wire enable wrong");
  spi_enable_a: assert property (
    ok |-> core_in.spi_enable == $past(sp, 3))
    else $error("spi enable wrong");
  ramp_step_a: assert property (
    ramp_s |-> motor.step == $past(core_out.ramp_step))
    else $error("ramp step wrong");
  ext_step_a: assert property (
    ok && $past(sd, 3) && !$past(br, 3) |-> motor.step == $past(pins_in.left_ref_or_step_in, 3))
    else $error("external step wrong");
  index_dir_a: assert property (
    ok |-> pins_out.enc_n_oe == $past(sd, 3))
    else $error("index pin drive wrong");
  bridge_float_a: assert property (
    ok |-> motor.outputs_float == $past(br, 3) && motor.power_enable != $past(br, 3))
    else $error("bridge state wrong");
  wire_lines_a: assert property (
    core_in.wire_enable |-> pins_out.diag_first_oe == $past(core_out.wire_tx_en)
      && pins_out.diag_first_o != $past(core_out.wire_tx))
    else $error("wire lines wrong");
  lost_pulse_a: assert property (
    drop_s |-> clk_lost ##1 !clk_lost)
    else $error("clock loss pulse wrong");
endmodule : mode_pin_function_mux_assertions

bind mode_pin_function_mux mode_pin_function_mux_assertions mode_pin_function_mux_assertions_inst (
  .clock(clock), .arst_n(arst_n), .pins_in(pins_in), .pins_out(pins_out),
  .core_out(core_out), .core_in(core_in), .motor(motor),
  .clk_use_external(clk_use_external), .clk_lost(clk_lost));
`default_nettype wire

// *** tb/host_pin_model.sv ***
// Host and board model resolving the two-way pins
`timescale 1ns/100ps
`default_nettype none

module host_pin_model
  import pin_mux_pkg::*;
(
  input  wire logic       clock,    // Core clock
  input  wire pin_out_t   pins_out, // Device pin drive
  input  wire logic       strap_so, // Board level, serial out pin
  input  wire logic       strap_ix, // Board level, index pin
  input  wire logic       wire_tx,  // Host wire data
  input  wire logic       wire_en,  // Host drives the wire
  input  wire logic       single,   // Negative line left open
  output var  logic [3:0] lines     // {sout, index, neg, pos}
);
  logic [3:0] oe;            // Device enables
  logic [3:0] dv;            // Device levels
  logic [3:0] hen;           // Host enables
  logic [3:0] hv;            // Host levels
  logic [3:0] last_r = 4'h0; // Previous line levels
  assign oe = {pins_out.sout_oe, pins_out.enc_n_oe,
               pins_out.diag_first_oe, pins_out.diag_second_oe};
  assign dv = {pins_out.sout_o, pins_out.enc_n_o,
               pins_out.diag_first_o, pins_out.diag_second_o};
  // Differential pair, or positive line only
  assign hen = {2'b11, wire_en & ~single, wire_en};
  assign hv  = {strap_so, strap_ix, ~wire_tx, wire_tx};
  // Device wins; a released line drifts, so stale values never pass
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lines[i] = oe[i] ? dv[i] : (hen[i] ? hv[i] : ~last_r[i]);
    end
    // Positive line has a pull-down
    if (!oe[0] && !hen[0]) begin
      lines[0] = 1'b0;
    end
  end
  // Remember levels for the drift
  always_ff @(posedge clock) begin
    last_r <= lines;
  end
endmodule : host_pin_model
`default_nettype wire

// *** tb/mode_pin_function_mux_tb.sv ***
// Self-checking bench for the pin function multiplexer
`timescale 1ns/100ps
`default_nettype none

module mode_pin_function_mux_tb;
  import pin_mux_pkg::*;
  localparam int LOSS = 8; // Shortened loss timeout
  logic       clock = 1'b0;
  logic       arst_n = 1'b0;
  pin_in_t    drv;      // Bench pin drive
  pin_in_t    pins_in;  // Resolved pin levels
  pin_out_t   pins_out;
  core_out_t  core_out;
  core_in_t   core_in;
  motor_t     motor;
  logic       clk_use_external;
  logic       clk_lost;
  logic       wtx = 1'b0; // Host wire data
  logic       wen = 1'b0; // Host wire drive
  logic       se = 1'b0;  // Host single-ended
  logic [3:0] lines;
  int         fail_count = 0;
  int         tests_run = 0;
  always #10 clock = ~clock;
  // Two-way pins take the resolved levels
  always_comb begin
    pins_in = drv;
    {pins_in.sout_or_strap0, pins_in.enc_index_or_speedctl_ready} = lines[3:2];
    {pins_in.diag_first_or_wire_neg, pins_in.diag_second_or_wire_pos} = lines[1:0];
  end
  mode_pin_function_mux #(.CLK_LOSS_CYCLES(LOSS), .LOSS_CNT_W(8)) mode_pin_function_mux_inst (
    .clock(clock), .arst_n(arst_n), .pins_in(pins_in), .pins_out(pins_out),
    .core_out(core_out), .core_in(core_in), .motor(motor),
    .clk_use_external(clk_use_external), .clk_lost(clk_lost));
  host_pin_model host_pin_model_inst (
    .clock(clock), .pins_out(pins_out), .strap_so(drv.sout_or_strap0),
    .strap_ix(drv.enc_index_or_speedctl_ready), .wire_tx(wtx), .wire_en(wen),
    .single(se), .lines(lines));
  // Count and report one comparison
  task automatic chk(input logic bad, input string msg);
    tests_run++;
    if (bad) begin
      fail_count++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask : chk
  // Verdict and end of run
  task automatic print_verdict();
    if (fail_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  // Expected outputs from the mode table; unused functions read 0, spi_chipsel_n reads 1
  task automatic model(input pin_in_t p, input core_out_t c,
                       output core_in_t ci, output pin_out_t po, output motor_t m);
    logic sd;
    logic sp;
    sd = p.step_dir_select;
    sp = p.serial_port_select;
    ci = '0;
    po = '0;
    ci.mode = mode_t'({sd, sp});
    {ci.spi_enable, ci.wire_enable} = {sp, !sd && !sp};
    {ci.standalone, ci.step_dir_active} = {sd && !sp, sd};
    ci.spi_chipsel_n = sp ? p.chipsel_or_strap3 : 1'b1;
    {ci.spi_sclk, ci.spi_sin} = {sp & p.sclk_or_strap2, sp & p.sin_or_strap1};
    ci.straps = {p.enc_index_or_speedctl_ready, p.enc_a_or_speedctl_gate,
                 p.enc_b_or_speedctl_enable, p.chipsel_or_strap3, p.sclk_or_strap2,
                 p.sin_or_strap1, p.sout_or_strap0};
    if (!sd) begin
      {ci.left_ref, ci.right_ref} = {p.left_ref_or_step_in, p.right_ref_or_dir_in};
      {ci.enc_a, ci.enc_b} = {p.enc_a_or_speedctl_gate, p.enc_b_or_speedctl_enable};
      ci.enc_index = p.enc_index_or_speedctl_ready;
    end else begin
      {po.enc_n_o, po.enc_n_oe} = {c.speedctl_ready, 1'b1};
    end
    if (sd && sp) begin
      ci.speedctl_enable = p.enc_b_or_speedctl_enable;
      ci.speedctl_gate = p.enc_a_or_speedctl_gate;
    end
    if (!sd && !sp) begin
      {ci.wire_rx, ci.next_addr_in} = {p.diag_second_or_wire_pos, p.sin_or_strap1};
      {po.sout_o, po.sout_oe} = {c.next_addr_out, 1'b1};
      {po.diag_first_o, po.diag_second_o} = {!c.wire_tx, c.wire_tx};
      {po.diag_first_oe, po.diag_second_oe} = {2{c.wire_tx_en}};
    end
    if (sp) begin
      {po.sout_o, po.sout_oe} = {c.spi_sout, c.spi_sout_en & !p.chipsel_or_strap3};
    end
    if (!sd && sp) begin
      {po.diag_first_o, po.diag_first_oe} = {c.diag_first & !c.diag_open_drain,
                                             !(c.diag_open_drain & c.diag_first)};
      {po.diag_second_o, po.diag_second_oe} = {c.diag_second & !c.diag_open_drain,
                                               !(c.diag_open_drain & c.diag_second)};
    end
    m.step = !p.bridge_disable_n & (sd ? p.left_ref_or_step_in : c.ramp_step);
    m.dir = sd ? p.right_ref_or_dir_in : c.ramp_dir;
    {m.power_enable, m.outputs_float} = {!p.bridge_disable_n, p.bridge_disable_n};
  endtask : model
  // Main sequence: every mode with random pins, then clock loss
  initial begin : main
    pin_in_t   t;
    core_out_t c;
    core_in_t  eci;
    pin_out_t  epo;
    motor_t    em;
    int        n;
    drv = '0;
    core_out = '0;
    n = $urandom(32'hAA3B0516);
    repeat (2) @(posedge clock);
    chk(core_in !== '0 || pins_out !== '0 || motor !== '0, "reset state");
    arst_n <= 1'b1;
    for (int md = 0; md < 4; md++) begin
      for (int k = 0; k < 8; k++) begin
        @(posedge clock);
        t = pin_in_t'($urandom);
        c = core_out_t'($urandom);
        t.ext_clock = 1'b0;
        {t.step_dir_select, t.serial_port_select} = md[1:0];
        drv <= t;
        core_out <= c;
        wtx <= 1'($urandom);
        wen <= !c.wire_tx_en;
        se <= 1'($urandom);
        repeat (6) @(posedge clock);
        #1;
        model(pins_in, core_out, eci, epo, em);
        chk(core_in !== eci, "core_in");
        chk(pins_out !== epo, "pins_out");
        chk(motor !== em, "motor");
        chk(clk_use_external !== 1'b0, "clock source");
      end
    end
    for (n = 0; n < 12; n++) begin
      @(posedge clock);
      drv.ext_clock <= n[0];
    end
    repeat (4) @(posedge clock);
    #1;
    chk(clk_use_external !== 1'b1, "external clock");
    n = 0;
    while (clk_lost !== 1'b1 && n < 200) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk(n < LOSS - 3 || n > LOSS + 6, "loss time");
    chk(clk_use_external !== 1'b0, "fail over");
    print_verdict();
  end
endmodule : mode_pin_function_mux_tb
`default_nettype wire
